/* logic/afc_pkg.sv */
// afc_pkg: constants shared by the front-end control block and its setup decoder.
// assumes a single 250 MHz clock domain and registers loaded over a register port.
package afc_pkg;
   // register offsets (register index on the parallel register port)
   localparam logic [5:0]  AFC_ADDR_ADC_CONTROL = 6'h01;
   localparam logic [5:0]  AFC_ADDR_IO_EXCITE   = 6'h03;
   localparam logic [5:0]  AFC_ADDR_CONFIG_0    = 6'h19;
   localparam int          AFC_NUM_SETUPS       = 8;
   // reset values
   localparam logic [23:0] AFC_IO_EXCITE_RESET  = 24'h000000;
   localparam logic [15:0] AFC_CONFIG_RESET     = 16'h0860;
   localparam logic [15:0] AFC_ADC_CTRL_RESET   = 16'h0000;
   // adc control fields
   localparam int          AFC_REF_EN_BIT       = 0;
   // configuration register fields
   localparam int          AFC_CFG_BIPOLAR_BIT  = 11;
   localparam int          AFC_CFG_BUFP_BIT     = 6;
   localparam int          AFC_CFG_BUFM_BIT     = 5;
   localparam int          AFC_CFG_REFSEL_LSB   = 3;
   localparam int          AFC_CFG_PGA_LSB      = 0;
   // io/excitation control fields
   localparam int          AFC_IO_LVL_B_BIT     = 23;
   localparam int          AFC_IO_LVL_A_BIT     = 22;
   localparam int          AFC_IO_EN_B_BIT      = 19;
   localparam int          AFC_IO_EN_A_BIT      = 18;
   localparam int          AFC_IO_SW_BIT        = 15;
   localparam int          AFC_IO_MAG_B_LSB     = 11;
   localparam int          AFC_IO_MAG_A_LSB     = 8;
   localparam int          AFC_IO_PIN_B_LSB     = 4;
   localparam int          AFC_IO_PIN_A_LSB     = 0;
   // reference sources
   typedef enum logic [1:0] {
      AFC_REF_EXT_A = 2'h0,
      AFC_REF_EXT_B = 2'h1,
      AFC_REF_INT   = 2'h2,
      AFC_REF_RSVD  = 2'h3
   } afc_ref_t;
   // conversion tracking states, gray order
   typedef enum logic [1:0] {
      AFC_IDLE = 2'h0,
      AFC_BUSY = 2'h1
   } afc_conv_t;
   localparam logic [23:0] AFC_MIDSCALE = 24'h800000;
endpackage

/* logic/afc_setup_decode.sv */
// afc_setup_decode: turns one latched setup into analog front-end controls.
// assumes the setup word is stable for a conversion; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module afc_setup_decode
   import afc_pkg::*;
(
   // setup word
   input  wire logic [15:0] setup_cfg,
   // decoded controls
   output logic       [1:0] stage_enable,
   output logic       [7:0] gain_factor,
   output logic             buffer_p_on,
   output logic             buffer_m_on,
   output logic             bipolar_mode,
   output logic       [1:0] ref_select
);
   logic [2:0] gain_code;
   assign gain_code = setup_cfg[AFC_CFG_PGA_LSB +: 3];

   // gain 1..128 as a one-hot power of two
   assign gain_factor = 8'h01 << gain_code;   // see RQ1

   // both stages bypassed at gain 1, one up to 8, two above
   always_comb begin
      if (gain_code == 3'h0) begin
         stage_enable = 2'h0;                  // see RQ2
      end else if (gain_code <= 3'h3) begin
         stage_enable = 2'h1;                  // see RQ2
      end else begin
         stage_enable = 2'h3;                  // see RQ2
      end
   end

   // any real gain needs the rail-to-rail buffered path
   assign buffer_p_on  = setup_cfg[AFC_CFG_BUFP_BIT] | (gain_code != 3'h0);  // see RQ15
   assign buffer_m_on  = setup_cfg[AFC_CFG_BUFM_BIT] | (gain_code != 3'h0);  // see RQ15
   assign bipolar_mode = setup_cfg[AFC_CFG_BIPOLAR_BIT];                    // see RQ5
   assign ref_select   = setup_cfg[AFC_CFG_REFSEL_LSB +: 2];                 // see RQ4
endmodule
`default_nettype wire

/* logic/afc_frontend.sv */
// afc_frontend: front-end control registers, per-setup latching and output coding.
// assumes register writes and conversion starts come from same-clock logic.
// Operation
// RQ1: gain 1 to 128 chosen by each setup's gain field.
// RQ2: gain 1 bypasses stages, 2 to 8 one stage, above 8 both.
// RQ3: internal reference enable bit powers the embedded reference.
// RQ4: each setup picks internal or one of two external references.
// RQ5: setup polarity bit picks unipolar or bipolar handling.
// RQ6: unipolar result is straight binary over 24 bits.
// RQ7: bipolar result is offset binary, zero input gives midscale.
// RQ8: two current sources each have independent magnitude field.
// RQ9: each current source routed to pin named by its select field.
// RQ10: both currents on the same pin is allowed, not an error.
// RQ11: excitation currents work regardless of reference enable.
// RQ12: bridge switch bit closes low-side switch when set.
// RQ13: 24-bit io control register layout, resets to zero.
// RQ14: aux outputs driven only when enabled, level follows data bit.
// RQ15: gain above 1 forces both input buffers on.
// RQ16: setting changes apply from next conversion, not the running one.
`timescale 1ns/1ps
`default_nettype none
module afc_frontend
   import afc_pkg::*;
#(
   parameter int NSETUP = AFC_NUM_SETUPS
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic  [5:0] reg_addr,
   input  wire logic [23:0] reg_wdata,
   output logic      [23:0] reg_rdata,
   // conversion control
   input  wire logic        conv_start,
   input  wire logic  [2:0] conv_setup,
   input  wire logic        conv_done,
   input  wire logic [23:0] conv_raw,
   output logic             conv_busy,
   output logic      [23:0] result_code,
   output logic             result_valid,
   // analog controls
   output logic       [1:0] pga_stage_enable,
   output logic       [7:0] pga_gain,
   output logic             ain_buffer_p_on,
   output logic             ain_buffer_m_on,
   output logic             bipolar_active,
   output logic       [1:0] ref_source,
   output logic             internal_ref_on,
   output logic       [2:0] excite_a_magnitude,
   output logic       [2:0] excite_b_magnitude,
   output logic       [3:0] excite_a_pin_select,
   output logic       [3:0] excite_b_pin_select,
   output logic             bridge_switch_on,
   // auxiliary outputs (tri-state)
   output logic             aux_out_a_level,
   output logic             aux_out_a_oe,
   output logic             aux_out_b_level,
   output logic             aux_out_b_oe
);
   ////////////////////////////////////////////////////////////////////////////
   logic [23:0] io_excite_ff;
   logic [15:0] adc_ctrl_ff;
   logic [15:0] config_ff [NSETUP];
   logic [15:0] active_cfg_ff;
   afc_conv_t   conv_state_ff;
   logic [23:0] result_ff;
   logic        valid_ff;
   logic        bip_w;

   // io/excitation register, reserved bits held at zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_excite_ff <= AFC_IO_EXCITE_RESET;                 // see RQ13
      end else if (reg_wr && reg_addr == AFC_ADDR_IO_EXCITE) begin
         io_excite_ff <= reg_wdata & 24'hcc_bf_ff;            // see RQ13
      end
   end

   // converter control, only reference enable is acted on here
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         adc_ctrl_ff <= AFC_ADC_CTRL_RESET;
      end else if (reg_wr && reg_addr == AFC_ADDR_ADC_CONTROL) begin
         adc_ctrl_ff <= reg_wdata[15:0];
      end
   end

   // setup configuration bank
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NSETUP; i++) begin
            config_ff[i] <= AFC_CONFIG_RESET;
         end
      end else if (reg_wr && reg_addr >= AFC_ADDR_CONFIG_0 &&
                   reg_addr < AFC_ADDR_CONFIG_0 + 6'(NSETUP)) begin
         config_ff[3'(reg_addr - AFC_ADDR_CONFIG_0)] <= reg_wdata[15:0] & 16'h0fff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion tracking; setup snapshot taken only at start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         conv_state_ff <= AFC_IDLE;
      end else begin
         case (conv_state_ff)
            AFC_IDLE: begin
               if (conv_start) begin
                  conv_state_ff <= AFC_BUSY;
               end
            end
            AFC_BUSY: begin
               if (conv_done) begin
                  conv_state_ff <= AFC_IDLE;
               end
            end
            default: conv_state_ff <= AFC_IDLE;
         endcase
      end
   end

   // later writes to the bank cannot reach a running conversion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         active_cfg_ff <= AFC_CONFIG_RESET;
      end else if (conv_state_ff == AFC_IDLE && conv_start) begin
         active_cfg_ff <= config_ff[conv_setup];   // see RQ16
      end
   end

   assign conv_busy = (conv_state_ff == AFC_BUSY);

   afc_setup_decode u_decode (
      .setup_cfg    (active_cfg_ff),
      .stage_enable (pga_stage_enable),
      .gain_factor  (pga_gain),
      .buffer_p_on  (ain_buffer_p_on),
      .buffer_m_on  (ain_buffer_m_on),
      .bipolar_mode (bip_w),
      .ref_select   (ref_source)
   );
   assign bipolar_active = bip_w;

   ////////////////////////////////////////////////////////////////////////////
   // output coding: raw is the signed two's-complement modulator result in
   // bipolar mode (msb flip gives offset binary), plain binary in unipolar
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         result_ff <= 24'h000000;
         valid_ff  <= 1'b0;
      end else begin
         valid_ff <= conv_busy && conv_done;
         if (conv_busy && conv_done) begin
            if (bip_w) begin
               result_ff <= conv_raw ^ AFC_MIDSCALE;   // see RQ7
            end else begin
               result_ff <= conv_raw;                  // see RQ6
            end
         end
      end
   end
   assign result_code  = result_ff;
   assign result_valid = valid_ff;

   ////////////////////////////////////////////////////////////////////////////
   // analog controls straight from registers; no cross-checks on purpose
   assign internal_ref_on     = adc_ctrl_ff[AFC_REF_EN_BIT];                 // see RQ3
   assign excite_a_magnitude  = io_excite_ff[AFC_IO_MAG_A_LSB +: 3];         // see RQ8, RQ11
   assign excite_b_magnitude  = io_excite_ff[AFC_IO_MAG_B_LSB +: 3];         // see RQ8, RQ11
   assign excite_a_pin_select = io_excite_ff[AFC_IO_PIN_A_LSB +: 4];         // see RQ9, RQ10
   assign excite_b_pin_select = io_excite_ff[AFC_IO_PIN_B_LSB +: 4];         // see RQ9, RQ10
   assign bridge_switch_on    = io_excite_ff[AFC_IO_SW_BIT];                 // see RQ12
   assign aux_out_a_oe        = io_excite_ff[AFC_IO_EN_A_BIT];               // see RQ14
   assign aux_out_b_oe        = io_excite_ff[AFC_IO_EN_B_BIT];               // see RQ14
   assign aux_out_a_level     = io_excite_ff[AFC_IO_LVL_A_BIT];              // see RQ14
   assign aux_out_b_level     = io_excite_ff[AFC_IO_LVL_B_BIT];              // see RQ14

   // read mux, unmapped reads zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 24'h000000;
      end else if (reg_rd) begin
         if (reg_addr == AFC_ADDR_IO_EXCITE) begin
            reg_rdata <= io_excite_ff;
         end else if (reg_addr == AFC_ADDR_ADC_CONTROL) begin
            reg_rdata <= {8'h00, adc_ctrl_ff};
         end else if (reg_addr >= AFC_ADDR_CONFIG_0 &&
                      reg_addr < AFC_ADDR_CONFIG_0 + 6'(NSETUP)) begin
            reg_rdata <= {8'h00, config_ff[3'(reg_addr - AFC_ADDR_CONFIG_0)]};
         end else begin
            reg_rdata <= 24'h000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   chk_io_reset_zero: assert property (@(posedge clk)   // see RQ13
      $rose(resetn) |-> io_excite_ff == 24'h000000)
      else $error("io control not zero after reset");

   chk_stage_gain1: assert property (@(posedge clk) disable iff (!resetn)   // see RQ2
      pga_gain == 8'h01 |-> pga_stage_enable == 2'h0)
      else $error("stages not bypassed at gain 1");

   chk_stage_high: assert property (@(posedge clk) disable iff (!resetn)   // see RQ2
      pga_gain > 8'h08 |-> pga_stage_enable == 2'h3)
      else $error("both stages not used above gain 8");

   chk_buffer_force: assert property (@(posedge clk) disable iff (!resetn)   // see RQ15
      pga_gain != 8'h01 |-> ain_buffer_p_on && ain_buffer_m_on)
      else $error("buffers not forced on with gain");

   chk_cfg_hold_busy: assert property (@(posedge clk) disable iff (!resetn)   // see RQ16
      conv_busy && !conv_done |=> $stable(pga_gain) && $stable(ref_source))
      else $error("settings changed mid conversion");

   chk_bipolar_zero: assert property (@(posedge clk) disable iff (!resetn)   // see RQ7
      conv_busy && conv_done && bip_w && conv_raw == 24'h000000
      |=> result_code == 24'h800000 && result_valid)
      else $error("bipolar zero not midscale");

   chk_unipolar_pass: assert property (@(posedge clk) disable iff (!resetn)   // see RQ6
      conv_busy && conv_done && !bip_w |=> result_code == $past(conv_raw))
      else $error("unipolar code altered");

   chk_io_write: assert property (@(posedge clk) disable iff (!resetn)   // see RQ12
      reg_wr && reg_addr == AFC_ADDR_IO_EXCITE
      |=> bridge_switch_on == $past(reg_wdata[15]) &&
          aux_out_a_oe == $past(reg_wdata[18]))
      else $error("io control write not applied");
endmodule
`default_nettype wire

/* sim/afc_sensor_model.sv */
// afc_sensor_model: stand-in for the modulator and sensor behind the front end.
// assumes conv_busy from the block; answers after a fixed count of cycles.
`timescale 1ns/1ps
`default_nettype none
module afc_sensor_model #(
   parameter int DELAY = 12
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // conversion handshake
   input  wire logic        conv_busy,
   input  wire logic [23:0] raw_value,
   output logic             conv_done,
   output logic      [23:0] conv_raw
);
   ////////////////////////////////////////
   logic [7:0] cnt_ff;
   logic       fired_ff;
   // count busy cycles, one done pulse per conversion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff    <= 8'h00;
         fired_ff  <= 1'b0;
         conv_done <= 1'b0;
      end else if (conv_busy && !fired_ff) begin
         cnt_ff    <= cnt_ff + 8'h01;
         fired_ff  <= (cnt_ff == 8'(DELAY));
         conv_done <= (cnt_ff == 8'(DELAY));
      end else begin
         cnt_ff    <= conv_busy ? cnt_ff : 8'h00;
         fired_ff  <= conv_busy & fired_ff;
         conv_done <= 1'b0;
      end
   end
   // stale word is flipped so a design that samples late never matches
   assign conv_raw = conv_done ? raw_value : ~raw_value;
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// tb_top: self-checking bench for the front-end control block.
// assumes the sensor model answers conversions; one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import afc_pkg::*;
;
   localparam logic [5:0] CFG2 = AFC_ADDR_CONFIG_0 + 6'h02;
   logic        clk, resetn, reg_wr, reg_rd, conv_start, conv_done, conv_busy, result_valid;
   logic        ain_buffer_p_on, ain_buffer_m_on, bipolar_active, internal_ref_on;
   logic        bridge_switch_on, aux_out_a_level, aux_out_a_oe, aux_out_b_level, aux_out_b_oe;
   logic [5:0]  reg_addr;
   logic [2:0]  conv_setup, excite_a_magnitude, excite_b_magnitude;
   logic [23:0] reg_wdata, reg_rdata, conv_raw, result_code, raw_value;
   logic [1:0]  pga_stage_enable, ref_source;
   logic [3:0]  excite_a_pin_select, excite_b_pin_select;
   logic [7:0]  pga_gain;
   int          fails, cmp_count;
   wire         aux_a_pin, aux_b_pin;
   // pin level as the board sees it, floating when not driven
   assign aux_a_pin = aux_out_a_oe ? aux_out_a_level : 1'bz;
   assign aux_b_pin = aux_out_b_oe ? aux_out_b_level : 1'bz;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   afc_frontend dut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .conv_start(conv_start), .conv_setup(conv_setup), .conv_done(conv_done),
      .conv_raw(conv_raw), .conv_busy(conv_busy), .result_code(result_code),
      .result_valid(result_valid), .pga_stage_enable(pga_stage_enable), .pga_gain(pga_gain),
      .ain_buffer_p_on(ain_buffer_p_on), .ain_buffer_m_on(ain_buffer_m_on),
      .bipolar_active(bipolar_active), .ref_source(ref_source),
      .internal_ref_on(internal_ref_on), .excite_a_magnitude(excite_a_magnitude),
      .excite_b_magnitude(excite_b_magnitude), .excite_a_pin_select(excite_a_pin_select),
      .excite_b_pin_select(excite_b_pin_select), .bridge_switch_on(bridge_switch_on),
      .aux_out_a_level(aux_out_a_level), .aux_out_a_oe(aux_out_a_oe),
      .aux_out_b_level(aux_out_b_level), .aux_out_b_oe(aux_out_b_oe));
   afc_sensor_model #(.DELAY(12)) sensor (.clk(clk), .resetn(resetn), .conv_busy(conv_busy),
      .raw_value(raw_value), .conv_done(conv_done), .conv_raw(conv_raw));
   ////////////////////////////////////////
   task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // strobes drop on the next edge, so back-to-back calls never collide
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [5:0] a, input logic [23:0] exp, input string what);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp, what);
   endtask
   task automatic start(input logic [2:0] s, input logic [23:0] raw);
      @(posedge clk);
      raw_value  <= raw;
      conv_start <= 1'b1;
      conv_setup <= s;
      @(posedge clk);
      conv_start <= 1'b0;
      #1;
   endtask
   task automatic finish_conv(input logic [23:0] exp);
      for (int i = 0; i < 64 && result_valid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      check({23'h0, result_valid}, 24'h1, "result valid");
      check(result_code, exp, "result code");
   endtask
   ////////////////////////////////////////
   task automatic t_io();
      rd(AFC_ADDR_IO_EXCITE, 24'h000000, "io reset");
      check({22'h0, aux_a_pin, aux_b_pin}, {22'h0, 2'bzz}, "aux float");
      wr(AFC_ADDR_IO_EXCITE, 24'h4c9577);
      rd(AFC_ADDR_IO_EXCITE, 24'h4c9577, "io readback");
      check({16'h0, excite_b_pin_select, excite_a_pin_select}, 24'h77, "pins");
      check({23'h0, internal_ref_on}, 24'h0, "ref off");
      check({18'h0, excite_b_magnitude, excite_a_magnitude}, 24'h15, "mag ref off");
      check({23'h0, bridge_switch_on}, 24'h1, "switch closed");
      check({22'h0, aux_a_pin, aux_b_pin}, 24'h2, "aux driven");
      for (int m = 0; m < 8; m++) begin
         wr(AFC_ADDR_IO_EXCITE, {8'hc0, 2'h0, ~3'(m), 3'(m), 8'h3c});
         check({18'h0, excite_b_magnitude, excite_a_magnitude}, {18'h0, ~3'(m), 3'(m)}, "mag");
         check({22'h0, aux_a_pin, aux_b_pin, bridge_switch_on}, {21'h0, 3'bzz0}, "off");
      end
      wr(6'h3e, 24'hffffff);
      rd(6'h3e, 24'h000000, "unmapped");
      rd(AFC_ADDR_IO_EXCITE, 24'hc0073c, "io kept");
      wr(AFC_ADDR_IO_EXCITE, 24'h8c0000);
      check({22'h0, aux_a_pin, aux_b_pin}, 24'h1, "aux b driven");
   endtask
   task automatic t_gain();
      rd(CFG2, {8'h00, AFC_CONFIG_RESET}, "config reset");
      for (int k = 0; k < 8; k++) begin
         wr(CFG2, 24'(k));
         start(3'h2, 24'h123456);
         check({16'h0, pga_gain}, 24'h1 << k, "gain");
         check(24'($countones(pga_stage_enable)), (k == 0) ? 0 : (k < 4) ? 1 : 2, "stages");
         check({22'h0, ain_buffer_p_on, ain_buffer_m_on}, (k == 0) ? 0 : 3, "buffers");
         finish_conv(24'h123456);
      end
   endtask
   task automatic t_ref();
      wr(AFC_ADDR_ADC_CONTROL, 24'h000001);
      check({23'h0, internal_ref_on}, 24'h1, "ref enable");
      for (int r = 0; r < 3; r++) begin
         wr(CFG2, 24'(r) << 3);
         start(3'h2, 24'h000000);
         check({22'h0, ref_source}, 24'(r), "ref select");
         finish_conv(24'h000000);
      end
      wr(AFC_ADDR_ADC_CONTROL, 24'h000000);
      check({23'h0, internal_ref_on}, 24'h0, "ref disable");
   endtask
   // raw words span both ends and both sides of midscale; bipolar codes written out
   task automatic t_code();
      logic [23:0] raws [4] = '{24'h000000, 24'h800000, 24'h7fffff, 24'hffffff};
      logic [23:0] bips [4] = '{24'h800000, 24'h000000, 24'hffffff, 24'h7fffff};
      for (int b = 0; b < 2; b++) begin
         wr(CFG2, (b == 1) ? 24'h000800 : 24'h000000);
         for (int i = 0; i < 4; i++) begin
            start(3'h2, raws[i]);
            check({23'h0, bipolar_active}, 24'(b), "polarity");
            finish_conv((b == 1) ? bips[i] : raws[i]);
         end
      end
   endtask
   task automatic t_hold();
      wr(CFG2, 24'h000001);
      start(3'h2, 24'h00abcd);
      wr(CFG2, 24'h000007);
      check({16'h0, pga_gain}, 24'h02, "held gain");
      check({23'h0, conv_busy}, 24'h1, "busy");
      start(3'h0, 24'h00abcd);
      check({16'h0, pga_gain}, 24'h02, "busy start");
      finish_conv(24'h00abcd);
      check({23'h0, conv_busy}, 24'h0, "idle after done");
      start(3'h2, 24'h000000);
      check({16'h0, pga_gain}, 24'h80, "new gain");
      finish_conv(24'h000000);
   endtask
   // mid-run reset with io and gain away from their reset values
   task automatic t_reset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1;
      check({22'h0, aux_a_pin, aux_b_pin}, {22'h0, 2'bzz}, "aux after reset");
      check({16'h0, pga_gain}, 24'h01, "gain after reset");
      rd(AFC_ADDR_IO_EXCITE, 24'h000000, "io after reset");
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      resetn     = 1'b0;
      {reg_wr, reg_rd, conv_start} = 3'h0;
      reg_addr   = 6'h00;
      reg_wdata  = 24'h000000;
      conv_setup = 3'h0;
      raw_value  = 24'h000000;
      fails      = 0;
      cmp_count  = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_io();
      t_gain();
      t_ref();
      t_code();
      t_hold();
      t_reset();
      print_verdict();
   end
   // whole run is under a thousand cycles; this cuts a hang short
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire
